/* File: logic/upsg_gate.sv */
// Serial port power-save gate with APB registers and transmit buffer
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module upsg_gate #(
  parameter int DW = 8,
  parameter int DEPTH = 2,
  parameter int FRAME_CYC = upsg_pkg::FRAME_CYC,
  parameter int WAKE_CYC = upsg_pkg::WAKE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Modem lines, active low; the receive data line idles high
  input wire logic rts_n_i,
  input wire logic dtr_n_i,
  input wire logic rxd_i,
  output logic cts_n_o,
  // Receive characters from the serial core
  input wire logic rx_char_valid_i,
  input wire logic [DW-1:0] rx_char_i,
  output logic rx_char_valid_o,
  output logic [DW-1:0] rx_char_o,
  // Transmit characters in and out
  input wire logic tx_valid_i,
  input wire logic [DW-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_valid_o,
  output logic [DW-1:0] tx_data_o,
  input wire logic tx_ready_i,
  // Module activity and power state
  input wire logic sched_wake_i,
  input wire logic activity_i,
  output logic port_en_o,
  output logic low_power_o
);
  import upsg_pkg::*;

  localparam int DIV_W = $clog2(FRAME_CYC + 1);
  localparam int WK_W = $clog2(WAKE_CYC + 1);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    upsg_mode_e mode;
    logic flow;
    logic [15:0] timeout;
    logic [15:0] timer;
    logic [DIV_W-1:0] div;
    logic [WK_W-1:0] wake;
    upsg_wake_e wst;
    logic rxd_q;
    logic rx_vld;
    logic [DW-1:0] rx_dat;
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] cnt;
    logic [31:0] prdata;
  } upsg_state_s;

  upsg_state_s q;
  upsg_state_s nxt_q;

  // ==========================================================
  // Address decode
  function automatic logic [3:0] upsg_dec(input logic [11:0] a);
    logic [3:0] hit;
    hit = 4'h0;
    hit[0] = (a == CTRL_OFF);
    hit[1] = (a == TIMEOUT_OFF);
    hit[2] = (a == STATUS_OFF);
    hit[3] = (a == TIMER_OFF);
    return hit;
  endfunction

  logic line_mode;
  logic cyc;
  logic line_on;
  logic tx_pend;
  logic timer_run;
  logic waking;
  logic rx_ok;
  logic tick;
  logic rxd_rise;
  logic wake_done;
  logic push;
  logic pop;
  logic access;
  logic wr_err;
  logic [3:0] hit;
  logic [1:0] wr_mode;
  logic wr_flow;

  assign cyc = (q.mode == MODE_CYC);
  assign line_mode = (q.mode == MODE_RTS) || (q.mode == MODE_DTR);
  assign line_on = ((q.mode == MODE_RTS) && !rts_n_i) ||
                   ((q.mode == MODE_DTR) && !dtr_n_i);
  assign tx_pend = (q.cnt != '0);
  assign timer_run = (q.timer != 16'h0000);
  assign waking = (q.wst == W_WAKE);
  assign tick = (q.div == DIV_W'(FRAME_CYC - 1)); // see [RULE_17]
  assign rxd_rise = rxd_i && !q.rxd_q; // see [RULE_16]
  assign wake_done = waking && (q.wake == WK_W'(WAKE_CYC - 1));

  // ==========================================================
  // Receive acceptance and port enable
  always_comb begin
    case (q.mode)
      MODE_OFF: rx_ok = 1'b1; // see [RULE_02]
      MODE_CYC: rx_ok = !waking &&
                        (sched_wake_i || tx_pend || timer_run);
      default: rx_ok = line_on && (q.wst == W_ON); // see [RULE_08]
    endcase
  end

  // see [RULE_18] [RULE_09] [RULE_10]
  assign port_en_o = (q.mode == MODE_OFF) || sched_wake_i || tx_pend ||
                     line_on || timer_run;
  assign cts_n_o = !rx_ok; // see [RULE_13]
  // see [RULE_14]
  assign low_power_o = (q.mode != MODE_OFF) && !port_en_o && !waking &&
                       !activity_i;

  // ==========================================================
  // Transmit buffer; a stalled receiver fills it and stalls the source
  assign tx_ready_o = (q.cnt != (PW+1)'(DEPTH));
  // see [RULE_03] [RULE_04]
  assign tx_valid_o = tx_pend && !(q.flow && rts_n_i);
  assign tx_data_o = q.mem[q.rptr];
  assign push = tx_valid_i && tx_ready_o;
  assign pop = tx_valid_o && tx_ready_i;

  // ==========================================================
  // APB, no wait states; read data is staged in the setup cycle
  assign hit = upsg_dec(paddr_i);
  assign access = psel_i && penable_i;
  assign wr_mode = pwdata_i[CTRL_MODE_LSB +: 2];
  assign wr_flow = pwdata_i[CTRL_FLOW_BIT];
  always_comb begin
    wr_err = 1'b0;
    if (hit == 4'h0) begin
      wr_err = 1'b1;
    end else if (pwrite_i) begin
      // see [RULE_07]
      if (hit[0] && wr_mode == MODE_RTS && wr_flow) begin
        wr_err = 1'b1;
      end
      // see [RULE_12]
      if (hit[1] && (pwdata_i[15:0] < TIMEOUT_MIN ||
                     pwdata_i[15:0] > TIMEOUT_MAX)) begin
        wr_err = 1'b1;
      end
      if (hit[2] || hit[3]) begin
        wr_err = 1'b1;
      end
    end
  end
  assign pready_o = 1'b1;
  assign pslverr_o = access && wr_err;
  assign prdata_o = q.prdata;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_q = q;
    nxt_q.div = tick ? '0 : q.div + DIV_W'(1);
    nxt_q.rxd_q = rxd_i;

    // Wake sequencing; the first character of a wake is never valid
    case (q.wst)
      W_OFF: begin
        nxt_q.wake = '0;
        // see [RULE_06] [RULE_16]
        if (cyc && !q.flow && !rx_ok && rxd_rise) begin
          nxt_q.wst = W_WAKE;
        end
        if (line_mode && line_on) begin
          nxt_q.wst = W_WAKE; // see [RULE_15]
        end
      end
      W_WAKE: begin
        nxt_q.wake = q.wake + WK_W'(1);
        if (line_mode && !line_on) begin
          nxt_q.wst = W_OFF;
        end else if (wake_done) begin
          nxt_q.wst = W_ON;
        end else if (q.mode == MODE_OFF) begin
          nxt_q.wst = W_OFF;
        end
      end
      W_ON: begin
        if ((line_mode && !line_on) || q.mode == MODE_OFF ||
            (cyc && !timer_run)) begin
          nxt_q.wst = W_OFF;
        end
      end
      default: nxt_q.wst = W_OFF;
    endcase

    // Received characters pass only while the port accepts
    nxt_q.rx_vld = rx_char_valid_i && rx_ok; // see [RULE_06] [RULE_08]
    if (rx_char_valid_i) begin
      nxt_q.rx_dat = rx_char_i;
    end

    // Inactivity timer counted in radio frames
    if (!cyc) begin
      nxt_q.timer = 16'h0000;
    end else if ((rx_char_valid_i && rx_ok) || wake_done) begin
      nxt_q.timer = q.timeout; // see [RULE_11]
    end else if (tick && timer_run) begin
      nxt_q.timer = q.timer - 16'h0001; // see [RULE_17]
    end

    // Buffer pointers
    if (push) begin
      nxt_q.mem[q.wptr] = tx_data_i;
      nxt_q.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : q.wptr + PW'(1);
    end
    if (pop) begin
      nxt_q.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : q.rptr + PW'(1);
    end
    nxt_q.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);

    // Register writes take effect at the access edge
    if (access && pwrite_i && !wr_err) begin
      if (hit[0]) begin
        nxt_q.mode = upsg_mode_e'(wr_mode); // see [RULE_01]
        nxt_q.flow = wr_flow;
        nxt_q.wst = W_OFF;
      end
      if (hit[1]) begin
        nxt_q.timeout = pwdata_i[15:0];
      end
    end

    // Read data staged during setup
    if (psel_i && !penable_i && !pwrite_i) begin
      nxt_q.prdata = 32'h0000_0000;
      if (hit[0]) begin
        nxt_q.prdata[CTRL_MODE_LSB +: 2] = q.mode;
        nxt_q.prdata[CTRL_FLOW_BIT] = q.flow;
      end
      if (hit[1]) begin
        nxt_q.prdata[15:0] = q.timeout;
      end
      if (hit[2]) begin
        nxt_q.prdata[STAT_PORT_BIT] = port_en_o;
        nxt_q.prdata[STAT_IDLE_BIT] = low_power_o;
        nxt_q.prdata[STAT_RUN_BIT] = timer_run;
        nxt_q.prdata[STAT_WAKE_BIT] = waking;
        nxt_q.prdata[STAT_RXOK_BIT] = rx_ok;
        nxt_q.prdata[STAT_CNT_LSB +: PW+1] = q.cnt;
      end
      if (hit[3]) begin
        nxt_q.prdata[15:0] = q.timer;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.mode <= MODE_RST;
      q.flow <= FLOW_RST;
      q.timeout <= TIMEOUT_RST;
      q.wst <= W_OFF;
      // Receive line idles high; a zero here would fake an edge
      q.rxd_q <= 1'b1;
    end else begin
      q <= nxt_q;
    end
  end

  assign rx_char_valid_o = q.rx_vld;
  assign rx_char_o = q.rx_dat;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_mode0_cts_on: assert property ( // see [RULE_02]
    q.mode == MODE_OFF |-> !cts_n_o && port_en_o && !low_power_o)
    else $error("mode 0 must keep port on");
  a_flow_tx_hold: assert property ( // see [RULE_03]
    q.flow && rts_n_i |-> !tx_valid_o)
    else $error("transmit while RTS off with flow");
  a_noflow_tx_go: assert property ( // see [RULE_04]
    !q.flow && tx_pend |-> tx_valid_o && port_en_o)
    else $error("pending data not offered");
  a_rts_flow_bar: assert property ( // see [RULE_07]
    !(q.mode == MODE_RTS && q.flow))
    else $error("RTS mode with flow control");
  a_line_rx_drop: assert property ( // see [RULE_08]
    line_mode && !line_on && rx_char_valid_i |=> !rx_char_valid_o)
    else $error("character passed while line off");
  a_wake_rx_drop: assert property ( // see [RULE_06]
    cyc && waking && rx_char_valid_i |=> !rx_char_valid_o)
    else $error("character passed during wake");
  a_timer_restart: assert property ( // see [RULE_11]
    cyc && rx_char_valid_i && rx_ok && !(access && pwrite_i)
    |=> q.timer == $past(q.timeout))
    else $error("timer not restarted");
  a_timeout_range: assert property ( // see [RULE_12]
    q.timeout >= TIMEOUT_MIN && q.timeout <= TIMEOUT_MAX)
    else $error("timeout out of range");
  a_frame_step: assert property ( // see [RULE_17]
    cyc && tick && timer_run && !rx_char_valid_i && !wake_done &&
    !(access && pwrite_i) |=> q.timer == $past(q.timer) - 16'h0001)
    else $error("timer did not step on tick");
  a_cts_port_en: assert property ( // see [RULE_13]
    !cts_n_o |-> port_en_o || (q.wst == W_ON))
    else $error("CTS on while port disabled");
  a_line_wakes: assert property ( // see [RULE_15]
    line_mode && line_on && q.wst == W_OFF && !(access && pwrite_i)
    |=> waking)
    else $error("line did not start wake");
  a_rxd_wakes: assert property ( // see [RULE_16]
    cyc && !q.flow && !rx_ok && rxd_rise && q.wst == W_OFF &&
    !(access && pwrite_i) |=> waking ##1 cts_n_o)
    else $error("receive edge did not wake");
  a_idle_quiet: assert property ( // see [RULE_14]
    low_power_o |-> !port_en_o && !activity_i && cts_n_o)
    else $error("idle while active");
  a_cyc_port_off: assert property ( // see [RULE_09]
    cyc && !sched_wake_i && !tx_pend && !timer_run |-> !port_en_o)
    else $error("cyclic port on without cause");
  a_line_rx_pass: assert property ( // see [RULE_08]
    line_on && q.wst == W_ON && rx_char_valid_i |=> rx_char_valid_o)
    else $error("character lost while line on");

  c_cyc_wake: cover property (cyc && rxd_rise && q.wst == W_OFF);
  c_buf_full: cover property (!tx_ready_o && tx_valid_i);
  c_line_rx: cover property (line_mode && rx_char_valid_o);
  c_timer_out: cover property (cyc && q.timer == 16'h0001 && tick);

endmodule

/* File: logic/upsg_pkg.sv */
// Constants, types and register map of the serial power-save gate
// How it works
// [RULE_01] Modes: 0 off (reset), 1 cyclic, 2 RTS, 3 DTR
// [RULE_02] Mode 0: never idle, port and CTS on
// [RULE_03] Flow on: hold transmit while RTS off
// [RULE_04] Flow off: transmit regardless of RTS, no retry
// [RULE_05] Cyclic with flow: host waits for CTS on
// [RULE_06] Cyclic without flow: early character dropped, wakes port
// [RULE_07] RTS-gated mode refused while flow control on
// [RULE_08] Line modes: drop receive while line off
// [RULE_09] Cyclic: port off, woken by scheduled activity
// [RULE_10] Pending transmit data enables the port
// [RULE_11] Cyclic: each character restarts frame inactivity timer
// [RULE_12] Timeout 40 to 65000 frames, default 2000
// [RULE_13] CTS low while port accepts, high otherwise
// [RULE_14] Idle only when nothing needs the active state
// [RULE_15] Line rising wakes port after about 20 ms
// [RULE_16] Cyclic without flow: rising receive line wakes
// [RULE_17] Timer advances on a 4.615 ms frame tick
// [RULE_18] Port enable ORs mode 0, schedule, data, line, timer
package upsg_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] TIMEOUT_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] TIMER_OFF = 12'h00c;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FLOW_BIT = 2;
  localparam int STAT_PORT_BIT = 0;
  localparam int STAT_IDLE_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_WAKE_BIT = 3;
  localparam int STAT_RXOK_BIT = 4;
  localparam int STAT_CNT_LSB = 8;

  // ==========================================================
  // Modes and reset values
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_CYC = 2'h1,
    MODE_RTS = 2'h2,
    MODE_DTR = 2'h3
  } upsg_mode_e;

  typedef enum logic [2:0] {
    W_OFF = 3'h1,
    W_WAKE = 3'h2,
    W_ON = 3'h4
  } upsg_wake_e;

  localparam upsg_mode_e MODE_RST = MODE_OFF;
  localparam logic FLOW_RST = 1'h0;
  localparam logic [15:0] TIMEOUT_RST = 16'h07d0;
  localparam logic [15:0] TIMEOUT_MIN = 16'h0028;
  localparam logic [15:0] TIMEOUT_MAX = 16'hfde8;

  // ==========================================================
  // Timing at a 125 MHz clock
  localparam int CLK_NS = 8;
  localparam int FRAME_NS = 4615000;
  localparam int WAKE_NS = 20000000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;

endpackage

/* File: tb/upsg_gate_tb.sv */
// Self-checking bench for the serial power-save gate
`timescale 1ns/100ps
module upsg_gate_tb;
  import upsg_pkg::*;
  // Short frame and wake counts keep the run small
  localparam int FR = 20;
  localparam int WK = 10;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rts_n = 1'h1;
  logic dtr_n = 1'h1;
  logic tv = 1'h0;
  logic [7:0] td = 8'h00;
  logic [7:0] chr = 8'h00;
  logic send = 1'h0;
  logic hold = 1'h0;
  logic stall = 1'h1;
  logic sched = 1'h0;
  logic act = 1'h0;
  logic pready, pslverr, cts_n, rxd, rxv, rxv_o, tv_o, tr_o, trdy, pen, lp;
  logic [31:0] prdata;
  logic [7:0] rxc, rxc_o, td_o, rx_last;
  logic [7:0] txq [$];
  logic [31:0] q;
  logic e;
  int mismatches = 0;
  int comparisons = 0;
  int rx_cnt = 0;
  int n;

  upsg_gate #(.FRAME_CYC(FR), .WAKE_CYC(WK)) dut_u (.clk_i(clk),
    .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .rts_n_i(rts_n),
    .dtr_n_i(dtr_n), .rxd_i(rxd), .cts_n_o(cts_n), .rx_char_valid_i(rxv),
    .rx_char_i(rxc), .rx_char_valid_o(rxv_o), .rx_char_o(rxc_o),
    .tx_valid_i(tv), .tx_data_i(td), .tx_ready_o(tr_o), .tx_valid_o(tv_o),
    .tx_data_o(td_o), .tx_ready_i(trdy), .sched_wake_i(sched),
    .activity_i(act), .port_en_o(pen), .low_power_o(lp));

  upsg_host host_u (.clk_i(clk), .send_i(send), .hold_i(hold),
    .stall_i(stall), .char_i(chr), .cts_n_i(cts_n), .rxd_o(rxd),
    .rx_valid_o(rxv), .rx_char_o(rxc), .tx_ready_o(trdy));

  always #4 clk = ~clk;

  // ==========================================================
  // Monitors of both data streams
  always @(posedge clk) begin
    if (rxv_o === 1'h1) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rxc_o;
    end
    if (tv_o === 1'h1 && trdy === 1'h1) begin
      txq.push_back(td_o);
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task step(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Master holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge so psel is never driven twice in one step
    @(posedge clk);
  endtask

  task snd(input logic [7:0] c);
    chr <= c;
    send <= 1'h1;
    @(posedge clk);
    send <= 1'h0;
    step(6);
  endtask

  task push(input logic [7:0] a, input logic [7:0] b, input int k);
    tv <= 1'h1;
    td <= a;
    @(posedge clk);
    if (k == 2) begin
      td <= b;
      @(posedge clk);
    end
    tv <= 1'h0;
  endtask

  task t_reset;
    chk(cts_n, 1'h0);
    chk(pen, 1'h1);
    chk(lp, 1'h0);
    apb(1'h0, CTRL_OFF, 32'h0);
    chk(pready, 1'h1);
    chk(q, 32'h0);
    apb(1'h0, TIMEOUT_OFF, 32'h0);
    chk(q, 32'h7d0);
    $display("reset test done");
  endtask

  task t_regs;
    apb(1'h1, TIMEOUT_OFF, 32'h27);
    chk(e, 1'h1);
    apb(1'h1, TIMEOUT_OFF, 32'hfde9);
    chk(e, 1'h1);
    apb(1'h1, TIMEOUT_OFF, 32'h28);
    chk(e, 1'h0);
    apb(1'h1, CTRL_OFF, 32'h6);
    chk(e, 1'h1);
    apb(1'h0, CTRL_OFF, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk(e, 1'h1);
    apb(1'h1, STATUS_OFF, 32'h0);
    chk(e, 1'h1);
    $display("register test done");
  endtask

  task t_tx;
    apb(1'h1, CTRL_OFF, 32'h4);
    push(8'ha1, 8'hb2, 2);
    step(2);
    chk(tr_o, 1'h0);
    chk(tv_o, 1'h0);
    rts_n <= 1'h0;
    step(3);
    chk(tv_o, 1'h1);
    stall <= 1'h0;
    step(4);
    stall <= 1'h1;
    chk({txq[0], txq[1]}, 16'ha1b2);
    apb(1'h1, CTRL_OFF, 32'h0);
    rts_n <= 1'h1;
    push(8'hc3, 8'h00, 1);
    step(3);
    chk(tv_o, 1'h1);
    $display("transmit test done");
  endtask

  // Cyclic mode: idle port, wake by data, timer, schedule and host hold
  task t_cyc;
    apb(1'h1, CTRL_OFF, 32'h1);
    stall <= 1'h0;
    step(4);
    chk(txq[2], 8'hc3);
    chk(pen, 1'h0);
    chk(cts_n, 1'h1);
    chk(lp, 1'h1);
    // Other activity alone must keep the module out of idle
    act <= 1'h1;
    step(1);
    chk(lp, 1'h0);
    act <= 1'h0;
    apb(1'h0, STATUS_OFF, 32'h0);
    chk(q, 32'h1 << STAT_IDLE_BIT);
    n = rx_cnt;
    snd(8'h55);
    chk(rx_cnt, n);
    step(WK + 5);
    chk(cts_n, 1'h0);
    snd(8'h66);
    chk(rx_last, 8'h66);
    step(FR * 38);
    chk(pen, 1'h1);
    step(FR * 3);
    chk(pen, 1'h0);
    apb(1'h0, TIMER_OFF, 32'h0);
    chk(q, 32'h0);
    stall <= 1'h1;
    push(8'h3c, 8'h00, 1);
    step(2);
    chk(pen, 1'h1);
    stall <= 1'h0;
    apb(1'h1, CTRL_OFF, 32'h5);
    hold <= 1'h1;
    n = rx_cnt;
    snd(8'h77);
    chk(rx_cnt, n);
    sched <= 1'h1;
    step(6);
    chk(rx_last, 8'h77);
    sched <= 1'h0;
    hold <= 1'h0;
    $display("cyclic test done");
  endtask

  task setl(input int m, input logic v);
    if (m == 2) begin
      rts_n <= v;
    end else begin
      dtr_n <= v;
    end
  endtask

  task t_line;
    for (int m = 2; m < 4; m++) begin
      apb(1'h1, CTRL_OFF, m);
      chk(e, 1'h0);
      setl(m, 1'h1);
      step(2);
      chk(cts_n, 1'h1);
      n = rx_cnt;
      snd(8'h10);
      chk(rx_cnt, n);
      setl(m, 1'h0);
      step(WK + 5);
      chk(cts_n, 1'h0);
      snd(8'h20 + m[7:0]);
      chk(rx_last, 8'h20 + m[7:0]);
      setl(m, 1'h1);
    end
    $display("line test done");
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    step(10);
    nrst <= 1'h1;
    step(2);
    t_reset;
    t_regs;
    t_tx;
    t_cyc;
    t_line;
    print_verdict;
  end

  // Whole run needs about 1000 cycles
  initial begin
    step(20000);
    mismatches++;
    print_verdict;
  end
endmodule

/* File: tb/upsg_host.sv */
// Host-side model of the application processor on the serial lines
`timescale 1ns/100ps
module upsg_host (
  // Control from the bench
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic hold_i,
  input wire logic stall_i,
  input wire logic [7:0] char_i,
  // Lines facing the device
  input wire logic cts_n_i,
  output logic rxd_o,
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  output logic tx_ready_o
);
  logic pend;
  initial begin
    rxd_o = 1'h1;
    rx_valid_o = 1'h0;
    rx_char_o = 8'h00;
    pend = 1'h0;
  end
  // Stall holds off the device transmitter
  assign tx_ready_o = !stall_i;
  // ==========================================================
  // Character sender
  // Data bus toggles outside the strobe so stale data never matches
  always @(posedge clk_i) begin
    rx_valid_o <= 1'h0;
    rx_char_o <= ~rx_char_o;
    if (send_i) begin
      pend <= 1'h1;
    end
    if (!rxd_o) begin
      rxd_o <= 1'h1;
      rx_valid_o <= 1'h1;
      rx_char_o <= char_i;
    end else if (pend && !(hold_i && cts_n_i)) begin
      rxd_o <= 1'h0;
      pend <= 1'h0;
    end
  end
endmodule
